// *** rtl/aaadd_consts.vh ***
// Constants for the add/align/pc-relative/fp abs-add execution datapath
`ifndef AAADD_CONSTS_VH
`define AAADD_CONSTS_VH

// Operation select codes
`define AAADD_OP_W            4
`define AAADD_OP_ADD_TRAP     4'h0
`define AAADD_OP_ADD_NOTRAP   4'h1
`define AAADD_OP_ADD_IMM      4'h2
`define AAADD_OP_ALIGN        4'h3
`define AAADD_OP_PC_WORD      4'h4
`define AAADD_OP_PC_UPPER     4'h5
`define AAADD_OP_FP_ABS       4'h6
`define AAADD_OP_FP_ADD       4'h7

// Floating-point formats
`define AAADD_FMT_S           2'h0
`define AAADD_FMT_D           2'h1

// Rounding modes
`define AAADD_RM_NEAR         2'h0
`define AAADD_RM_ZERO         2'h1
`define AAADD_RM_PINF         2'h2
`define AAADD_RM_NINF         2'h3

// Cause / flag bit positions in the 5-bit vectors
`define AAADD_FLG_INEXACT     0
`define AAADD_FLG_UNDERFLOW   1
`define AAADD_FLG_OVERFLOW    2
`define AAADD_FLG_INVALID     4

// Fixed shift and mask figures
`define AAADD_WORD_SHIFT      2
`define AAADD_UPPER_SHIFT     16
`define AAADD_PC_WORD_MASK    32'hffff_fffc
`define AAADD_PC_UPPER_MASK   32'hffff_0000

// Format-dependent field figures
`define AAADD_S_EXP_W         8
`define AAADD_S_MAN_W         23
`define AAADD_D_EXP_W         11
`define AAADD_D_MAN_W         52

`endif

// *** rtl/aaadd_fp_add.v ***
// Floating-point adder core, one format per instance, combinational
`timescale 1ns/1ps
`include "aaadd_consts.vh"

module aaadd_fp_add #(
  parameter EW = 8,
  parameter MW = 23
) (
  // Operands
  input  wire [EW+MW:0] a_in,
  input  wire [EW+MW:0] b_in,
  input  wire [1:0]     rmode_in,
  // Result
  output reg  [EW+MW:0] sum_out,
  output reg  [4:0]     cause_out,
  output reg            unimpl_out
);

  localparam W  = EW + MW + 1;
  localparam GW = MW + 4;
  localparam [EW-1:0] EMAX = {EW{1'b1}};

  reg            sa;
  reg            sb;
  reg [EW-1:0]   ea;
  reg [EW-1:0]   eb;
  reg [MW:0]     ma;
  reg [MW:0]     mb;
  reg            nan_a;
  reg            nan_b;
  reg            inf_a;
  reg            inf_b;
  reg            swap;
  reg [EW-1:0]   ediff;
  reg [GW+1:0]   big;
  reg [GW+1:0]   sml;
  reg            sticky;
  reg [GW+1:0]   acc;
  reg            rsign;
  reg [EW+1:0]   rexp;
  reg [GW+1:0]   norm;
  reg            lsb;
  reg            grd;
  reg            stk;
  reg            rup;
  reg [MW+1:0]   rman;
  integer        i;
  integer        lz;

  ///////////////////////////////////////////////////////////////////////////
  // Denormal operands go to the trap path instead of a slower gradual path
  always @* begin
    sa      = a_in[W-1];
    sb      = b_in[W-1];
    ea      = a_in[W-2:MW];
    eb      = b_in[W-2:MW];
    ma      = {(ea != {EW{1'b0}}), a_in[MW-1:0]};
    mb      = {(eb != {EW{1'b0}}), b_in[MW-1:0]};
    nan_a   = (ea == EMAX) && (a_in[MW-1:0] != {MW{1'b0}});
    nan_b   = (eb == EMAX) && (b_in[MW-1:0] != {MW{1'b0}});
    inf_a   = (ea == EMAX) && !nan_a;
    inf_b   = (eb == EMAX) && !nan_b;
    swap    = {eb, mb} > {ea, ma};
    ediff   = swap ? (eb - ea) : (ea - eb);
    big     = {2'b00, (swap ? mb : ma), 3'b000};
    sml     = {2'b00, (swap ? ma : mb), 3'b000};
    sticky  = 1'b0;
    for (i = 0; i < GW + 2; i = i + 1) begin
      if (ediff > i && sml[0]) sticky = 1'b1;
      if (ediff > i) sml = {1'b0, sml[GW+1:1]};
    end
    sml[0]  = sml[0] | sticky;
    rsign   = swap ? sb : sa;
    acc     = (sa == sb) ? (big + sml) : (big - sml);
    rexp    = {2'b00, (swap ? eb : ea)};
    lz      = 0;
    for (i = GW; i >= 0; i = i - 1) begin
      if (acc[i] && lz == 0) lz = GW - i;
    end
    if (acc[GW+1]) begin
      norm = {1'b0, acc[GW+1:2], acc[1] | acc[0]};
      rexp = rexp + 1'b1;
    end else begin
      norm = acc << (lz - 1);
      rexp = rexp - lz[EW+1:0] + 1'b1;
    end
    lsb     = norm[3];
    grd     = norm[2];
    stk     = norm[1] | norm[0];
    case (rmode_in)
      `AAADD_RM_NEAR: rup = grd && (stk || lsb);
      `AAADD_RM_ZERO: rup = 1'b0;
      `AAADD_RM_PINF: rup = !rsign && (grd || stk);
      default:        rup = rsign && (grd || stk);
    endcase
    rman    = norm[GW:3] + {{MW+1{1'b0}}, rup};
    if (rman[MW+1]) rexp = rexp + 1'b1;
    cause_out  = 5'h00;
    unimpl_out = ((ea == {EW{1'b0}}) && (a_in[MW-1:0] != {MW{1'b0}})) ||
                 ((eb == {EW{1'b0}}) && (b_in[MW-1:0] != {MW{1'b0}}));
    cause_out[`AAADD_FLG_INEXACT] = grd | stk;
    sum_out    = {rsign, rexp[EW-1:0], rman[MW-1:0]};
    if (acc == {GW+2{1'b0}}) begin
      sum_out    = {(rmode_in == `AAADD_RM_NINF) && (sa != sb) ? 1'b1 : (sa & sb),
                    {W-1{1'b0}}};
      cause_out  = 5'h00;
    end else if (rexp[EW+1] || rexp[EW-1:0] == {EW{1'b0}}) begin
      sum_out    = {rsign, {W-1{1'b0}}};
      cause_out[`AAADD_FLG_UNDERFLOW] = 1'b1;
      cause_out[`AAADD_FLG_INEXACT]   = 1'b1;
    end else if (rexp[EW] || rexp[EW-1:0] == EMAX) begin
      sum_out    = {rsign, EMAX, {MW{1'b0}}};
      cause_out[`AAADD_FLG_OVERFLOW]  = 1'b1;
      cause_out[`AAADD_FLG_INEXACT]   = 1'b1;
    end
    if (nan_a || nan_b || (inf_a && inf_b && sa != sb)) begin
      sum_out    = {1'b0, EMAX, 1'b1, {MW-1{1'b0}}};
      cause_out  = 5'h00;
      cause_out[`AAADD_FLG_INVALID] = 1'b1;
    end else if (inf_a || inf_b) begin
      sum_out    = {(inf_a ? sa : sb), EMAX, {MW{1'b0}}};
      cause_out  = 5'h00;
    end
  end

endmodule

// *** rtl/aaadd_alu.v ***
// Execution datapath: integer adds, align, pc-relative and fp abs/add
`timescale 1ns/1ps
`include "aaadd_consts.vh"

// Operation
// - Trapping add overflows when sum bits 32,31 differ
// - No overflow: low sum word goes to destination
// - Non-trapping register add wraps, never traps
// - Immediate add sign-extends 16 bits, wraps, no trap
// - Word pc calc: imm19<<2 plus word-aligned pc
// - Pc operand is own address; no exception
// - Upper pc calc: imm16<<16 added to pc
// - Upper pc calc clears low sixteen bits
// - Two-bit byte pointer, all four values defined
// - Second source shifted left by eight times pointer
// - First source shifted right by four-minus-pointer bytes
// - Zero-fill shifts ORed into destination word
// - Arithmetic abs: NaN signals invalid operation
// - Non-arithmetic abs only clears sign bit
// - Fp add rounds exact sum per rounding mode
// - Cause bits ORed into sticky flags unless trap
// - Fp add reports unimpl/invalid/inexact/overflow/underflow
module aaadd_alu (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        rst_in,
  // Issue
  input  wire        issue_in,
  input  wire [3:0]  op_in,
  input  wire [4:0]  dest_in,
  input  wire [31:0] source_reg_a_in,
  input  wire [31:0] source_reg_b_in,
  input  wire [15:0] imm16_in,
  input  wire [18:0] imm19_in,
  input  wire [1:0]  byte_pointer_field_in,
  input  wire [31:0] pc_in,
  // Floating-point operands and control
  input  wire [1:0]  fmt_in,
  input  wire [63:0] fp_source_a_in,
  input  wire [63:0] fp_source_b_in,
  input  wire        cop1_usable_in,
  input  wire        ieee2008_capable_flag_in,
  input  wire        nonarith_magnitude_ctrl_in,
  input  wire [1:0]  rmode_in,
  input  wire [4:0]  trap_enable_in,
  input  wire        flags_clear_in,
  // Results
  output reg         result_valid_out,
  output reg  [4:0]  result_dest_out,
  output reg  [31:0] int_result_out,
  output reg         int_we_out,
  output reg  [63:0] fp_result_out,
  output reg         fp_we_out,
  // Exceptions and status
  output reg         int_overflow_exc_out,
  output reg         fp_exc_out,
  output reg         cop_unusable_exc_out,
  output reg         reserved_instr_exc_out,
  output reg         unimpl_op_exc_out,
  output reg  [4:0]  fp_cause_out,
  output reg  [4:0]  fp_flags_out
);

  localparam WIDTH = 32;

  // Idle/issue tracking, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;

  ///////////////////////////////////////////////////////////////////////////
  // Integer paths

  wire [32:0] trap_sum;
  wire        trap_ovf;
  wire [31:0] imm_ext;
  wire [31:0] imm_sum_nontrap;
  wire [31:0] reg_sum_nontrap;
  wire [31:0] word_off;
  wire [31:0] pc_word_offset_calc;
  wire [31:0] upper_off;
  wire [31:0] pc_upper_aligned_calc;
  wire [5:0]  left_amt;
  wire [5:0]  right_amt;
  wire [31:0] align_left;
  wire [31:0] align_right;
  wire [31:0] align_res;

  assign trap_sum  = {source_reg_a_in[31], source_reg_a_in} +
                     {source_reg_b_in[31], source_reg_b_in};
  assign trap_ovf  = trap_sum[32] != trap_sum[31];
  assign reg_sum_nontrap = source_reg_a_in + source_reg_b_in;
  assign imm_ext   = {{16{imm16_in[15]}}, imm16_in};
  assign imm_sum_nontrap = source_reg_a_in + imm_ext;
  // Pc is the calculating instruction's own address, not pc+4
  assign word_off  = {{11{imm19_in[18]}}, imm19_in, 2'b00};
  assign pc_word_offset_calc = (pc_in & `AAADD_PC_WORD_MASK) + word_off;
  assign upper_off = {imm16_in, 16'h0000};
  assign pc_upper_aligned_calc =
    (pc_in + upper_off) & `AAADD_PC_UPPER_MASK;
  // Pointer zero gives a full 32-bit right shift, which zero-fills in Verilog
  assign left_amt  = {1'b0, byte_pointer_field_in, 3'b000};
  assign right_amt = 6'h20 - left_amt;
  assign align_left  = source_reg_b_in << left_amt;
  assign align_right = source_reg_a_in >> right_amt;
  assign align_res   = align_left | align_right;

  ///////////////////////////////////////////////////////////////////////////
  // Floating-point paths

  wire [31:0] s_sum;
  wire [4:0]  s_cause;
  wire        s_unimpl;
  wire [63:0] d_sum;
  wire [4:0]  d_cause;
  wire        d_unimpl;
  wire        fmt_ok;
  wire        fmt_d;
  wire        abs_nan;
  wire        abs_arith;

  aaadd_fp_add #(
    .EW (`AAADD_S_EXP_W),
    .MW (`AAADD_S_MAN_W)
  ) u_add_s (
    .a_in       (fp_source_a_in[31:0]),
    .b_in       (fp_source_b_in[31:0]),
    .rmode_in   (rmode_in),
    .sum_out    (s_sum),
    .cause_out  (s_cause),
    .unimpl_out (s_unimpl)
  );

  aaadd_fp_add #(
    .EW (`AAADD_D_EXP_W),
    .MW (`AAADD_D_MAN_W)
  ) u_add_d (
    .a_in       (fp_source_a_in),
    .b_in       (fp_source_b_in),
    .rmode_in   (rmode_in),
    .sum_out    (d_sum),
    .cause_out  (d_cause),
    .unimpl_out (d_unimpl)
  );

  assign fmt_d   = fmt_in == `AAADD_FMT_D;
  assign fmt_ok  = fmt_d || (fmt_in == `AAADD_FMT_S);
  assign abs_nan = fmt_d ?
    ((fp_source_a_in[62:52] == 11'h7ff) && (fp_source_a_in[51:0] != 52'h0)) :
    ((fp_source_a_in[30:23] == 8'hff) && (fp_source_a_in[22:0] != 23'h0));
  // Either flag low forces the arithmetic form
  assign abs_arith = !ieee2008_capable_flag_in || !nonarith_magnitude_ctrl_in;

  ///////////////////////////////////////////////////////////////////////////
  // Result selection

  reg  [31:0] int_d;
  reg         int_we_d;
  reg  [63:0] fp_d;
  reg         fp_we_d;
  reg         ovf_d;
  reg         cu_d;
  reg         ri_d;
  reg         ui_d;
  reg  [4:0]  cause_d;
  reg         fpexc_d;
  reg  [4:0]  flags_d;
  reg  [4:0]  flags_q;

  always @* begin
    int_d    = 32'h0000_0000;
    int_we_d = 1'b0;
    fp_d     = 64'h0000_0000_0000_0000;
    fp_we_d  = 1'b0;
    ovf_d    = 1'b0;
    cu_d     = 1'b0;
    ri_d     = 1'b0;
    ui_d     = 1'b0;
    cause_d  = 5'h00;
    fpexc_d  = 1'b0;
    if (issue_in) begin
      case (op_in)
        `AAADD_OP_ADD_TRAP: begin
          int_d    = trap_sum[31:0];
          ovf_d    = trap_ovf;
          int_we_d = !trap_ovf;
        end
        `AAADD_OP_ADD_NOTRAP: begin
          int_d    = reg_sum_nontrap;
          int_we_d = 1'b1;
        end
        `AAADD_OP_ADD_IMM: begin
          int_d    = imm_sum_nontrap;
          int_we_d = 1'b1;
        end
        `AAADD_OP_ALIGN: begin
          int_d    = align_res;
          int_we_d = 1'b1;
        end
        `AAADD_OP_PC_WORD: begin
          int_d    = pc_word_offset_calc;
          int_we_d = 1'b1;
        end
        `AAADD_OP_PC_UPPER: begin
          int_d    = pc_upper_aligned_calc;
          int_we_d = 1'b1;
        end
        `AAADD_OP_FP_ABS: begin
          if (!cop1_usable_in) begin
            cu_d = 1'b1;
          end else if (!fmt_ok) begin
            ri_d = 1'b1;
          end else begin
            fp_d = fmt_d ? {1'b0, fp_source_a_in[62:0]} :
                           {32'h0000_0000, 1'b0, fp_source_a_in[30:0]};
            if (abs_arith && abs_nan) begin
              cause_d[`AAADD_FLG_INVALID] = 1'b1;
            end
          end
        end
        `AAADD_OP_FP_ADD: begin
          if (!cop1_usable_in) begin
            cu_d = 1'b1;
          end else if (!fmt_ok) begin
            ri_d = 1'b1;
          end else if (fmt_d ? d_unimpl : s_unimpl) begin
            ui_d = 1'b1;
          end else begin
            fp_d    = fmt_d ? d_sum : {32'h0000_0000, s_sum};
            cause_d = fmt_d ? d_cause : s_cause;
          end
        end
        default: begin
          ri_d = 1'b1;
        end
      endcase
      fpexc_d = |(cause_d & trap_enable_in);
      fp_we_d = (op_in == `AAADD_OP_FP_ABS || op_in == `AAADD_OP_FP_ADD) &&
                !cu_d && !ri_d && !ui_d && !fpexc_d;
    end
  end

  // A new cause wins over a clear arriving in the same cycle
  always @* begin
    flags_d = flags_clear_in ? 5'h00 : flags_q;
    if (issue_in && !fpexc_d && !ui_d) begin
      flags_d = flags_d | cause_d;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // State

  always @* begin
    case (state_q)
      ST_IDLE: state_d = issue_in ? ST_BUSY : ST_IDLE;
      ST_BUSY: state_d = issue_in ? ST_BUSY : ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  ///////////////////////////////////////////////////////////////////////////
  // Registered outputs, one cycle after issue, result and exception together

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q                <= ST_IDLE;
      flags_q                <= 5'h00;
      result_valid_out       <= 1'b0;
      result_dest_out        <= 5'h00;
      int_result_out         <= 32'h0000_0000;
      int_we_out             <= 1'b0;
      fp_result_out          <= 64'h0000_0000_0000_0000;
      fp_we_out              <= 1'b0;
      int_overflow_exc_out   <= 1'b0;
      fp_exc_out             <= 1'b0;
      cop_unusable_exc_out   <= 1'b0;
      reserved_instr_exc_out <= 1'b0;
      unimpl_op_exc_out      <= 1'b0;
      fp_cause_out           <= 5'h00;
      fp_flags_out           <= 5'h00;
    end else begin
      state_q                <= state_d;
      flags_q                <= flags_d;
      result_valid_out       <= issue_in;
      result_dest_out        <= dest_in;
      int_result_out         <= int_d;
      int_we_out             <= int_we_d;
      fp_result_out          <= fp_d;
      fp_we_out              <= fp_we_d;
      int_overflow_exc_out   <= ovf_d;
      fp_exc_out             <= fpexc_d;
      cop_unusable_exc_out   <= cu_d;
      reserved_instr_exc_out <= ri_d;
      unimpl_op_exc_out      <= ui_d;
      fp_cause_out           <= cause_d;
      fp_flags_out           <= flags_d;
    end
  end

endmodule

// *** test/aaadd_alu_chk.sv ***
// Concurrent checks on the execution datapath ports
`timescale 1ns/1ps
`include "aaadd_consts.vh"
module aaadd_alu_chk (
  // Clock, reset and issue
  input wire        mclk_in,
  input wire        rst_in,
  input wire        issue_in,
  input wire [3:0]  op_in,
  // Operands
  input wire [31:0] source_reg_a_in,
  input wire [31:0] source_reg_b_in,
  input wire [15:0] imm16_in,
  input wire [18:0] imm19_in,
  input wire [1:0]  byte_pointer_field_in,
  input wire [31:0] pc_in,
  input wire        ieee2008_capable_flag_in,
  input wire        nonarith_magnitude_ctrl_in,
  // Results
  input wire        result_valid_out,
  input wire [31:0] int_result_out,
  input wire        int_we_out,
  input wire        int_overflow_exc_out,
  input wire        fp_we_out,
  input wire        fp_exc_out,
  input wire [4:0]  fp_cause_out
);
  ////////////////////////////////////////////////////////////////////////////
  wire [32:0] sum33 = {source_reg_a_in[31], source_reg_a_in} +
                      {source_reg_b_in[31], source_reg_b_in};
  wire        ovf   = sum33[32] ^ sum33[31];
  wire [31:0] sum32 = sum33[31:0];
  wire [31:0] isum  = source_reg_a_in + {{16{imm16_in[15]}}, imm16_in};
  wire [31:0] pcw   = (pc_in & `AAADD_PC_WORD_MASK) + {{11{imm19_in[18]}}, imm19_in, 2'h0};
  wire [31:0] pcu   = (pc_in + {imm16_in, 16'h0}) & `AAADD_PC_UPPER_MASK;
  // Pointer zero gives a shift of 32, which must drop the first source entirely
  wire [31:0] algn  = (source_reg_b_in << {byte_pointer_field_in, 3'h0}) |
                      (source_reg_a_in >> (6'h20 - {byte_pointer_field_in, 3'h0}));
  wire        is_t  = issue_in && op_in == `AAADD_OP_ADD_TRAP;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  ////////////////////////////////////////////////////////////////////////////
  chk_valid_next: assert property (issue_in |=> result_valid_out)
    else $error("no result one cycle after issue");
  chk_trap_ovf: assert property (is_t |=> int_overflow_exc_out == $past(ovf)
    && int_we_out == !$past(ovf)) else $error("trap add overflow wrong");
  chk_trap_sum: assert property (is_t && !ovf |=> int_result_out == $past(sum32))
    else $error("trap add sum wrong");
  chk_wrap_add: assert property (issue_in && op_in == `AAADD_OP_ADD_NOTRAP
    |=> int_result_out == $past(sum32) && !int_overflow_exc_out) else $error("wrap add wrong");
  chk_imm_add: assert property (issue_in && op_in == `AAADD_OP_ADD_IMM
    |=> int_result_out == $past(isum) && !int_overflow_exc_out) else $error("imm add wrong");
  chk_pc_word: assert property (issue_in && op_in == `AAADD_OP_PC_WORD
    |=> int_result_out == $past(pcw) && int_we_out) else $error("pc word calc wrong");
  chk_pc_upper: assert property (issue_in && op_in == `AAADD_OP_PC_UPPER
    |=> int_result_out == $past(pcu) && int_we_out) else $error("pc upper calc wrong");
  chk_align_word: assert property (issue_in && op_in == `AAADD_OP_ALIGN
    |=> int_result_out == $past(algn)) else $error("align result wrong");
  chk_abs_quiet: assert property (issue_in && op_in == `AAADD_OP_FP_ABS &&
    ieee2008_capable_flag_in && nonarith_magnitude_ctrl_in |=> fp_cause_out == 5'h0
    && !fp_exc_out) else $error("non-arithmetic abs raised a cause");
  chk_fp_suppress: assert property (fp_exc_out |-> !fp_we_out)
    else $error("fp write despite exception");

  cov_overflow: cover property (is_t && ovf);
  cov_align3: cover property (issue_in && op_in == `AAADD_OP_ALIGN && byte_pointer_field_in == 2'h3);
  cov_fp_trap: cover property (fp_exc_out);
endmodule

bind aaadd_alu aaadd_alu_chk i_aaadd_alu_chk (.*);

// *** test/aaadd_wb_model.sv ***
// Writeback side model: integer register mirror fed by datapath results
`timescale 1ns/1ps
module aaadd_wb_model (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        rst_in,
  // Result stream
  input  wire        valid_in,
  input  wire        we_in,
  input  wire [4:0]  dest_in,
  input  wire [31:0] data_in,
  // Read back
  input  wire [4:0]  sel_in,
  output wire [31:0] data_out
);
  reg     [31:0] gpr_q [0:31];
  integer        i;
  // A write held back by an exception leaves the old word in place
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      for (i = 0; i < 32; i = i + 1) begin
        gpr_q[i] <= 32'h0;
      end
    end else if (valid_in && we_in) begin
      gpr_q[dest_in] <= data_in;
    end
  end
  assign data_out = gpr_q[sel_in];
endmodule

// *** test/tb_aaadd_alu.sv ***
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
`include "aaadd_consts.vh"
module tb_aaadd_alu;
  reg         mclk_in = 1'h0;
  reg         rst_in = 1'h1;
  reg         issue_in = 1'h0;
  reg  [3:0]  op_in = 4'h0;
  reg  [4:0]  dest_in = 5'h5;
  reg  [31:0] source_reg_a_in = 32'h0;
  reg  [31:0] source_reg_b_in = 32'h0;
  reg  [15:0] imm16_in = 16'h0;
  reg  [18:0] imm19_in = 19'h0;
  reg  [1:0]  byte_pointer_field_in = 2'h0;
  reg  [31:0] pc_in = 32'h0;
  reg  [1:0]  fmt_in = 2'h0;
  reg  [63:0] fp_source_a_in = 64'h0;
  reg  [63:0] fp_source_b_in = 64'h0;
  reg         cop1_usable_in = 1'h1;
  reg         ieee2008_capable_flag_in = 1'h1;
  reg         nonarith_magnitude_ctrl_in = 1'h1;
  reg  [1:0]  rmode_in = 2'h0;
  reg  [4:0]  trap_enable_in = 5'h0;
  reg         flags_clear_in = 1'h0;
  wire        result_valid_out, int_we_out, fp_we_out, int_overflow_exc_out, fp_exc_out;
  wire        cop_unusable_exc_out, reserved_instr_exc_out, unimpl_op_exc_out;
  wire [4:0]  result_dest_out, fp_cause_out, fp_flags_out;
  wire [31:0] int_result_out, wb_data;
  wire [63:0] fp_result_out;
  integer     errors = 0;
  integer     checks = 0;
  integer     cycles = 0;
  integer     k;
  localparam [127:0] AL_EXP = {32'hdd112233, 32'hccdd1122, 32'hbbccdd11, 32'haabbccdd};
  localparam [127:0] RM_EXP = {32'h3f800000, 32'h3f800001, 32'h3f800000, 32'h3f800000};

  aaadd_alu i_aaadd_alu (.*);
  aaadd_wb_model i_aaadd_wb_model (.mclk_in(mclk_in), .rst_in(rst_in),
    .valid_in(result_valid_out), .we_in(int_we_out), .dest_in(result_dest_out),
    .data_in(int_result_out), .sel_in(5'h5), .data_out(wb_data));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  // Whole run needs about 65 cycles; the ceiling leaves ample margin
  always @(posedge mclk_in) begin
    cycles = cycles + 1;
    if (cycles == 600) begin
      errors = errors + 1;
      end_of_test;
    end
  end

  task end_of_test;
    begin
      if (errors == 0 && checks > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask

  task cmp(input [63:0] got, input [63:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  // Issue for one cycle; outputs are then settled until the next posedge
  task run(input [3:0] op);
    begin
      @(negedge mclk_in);
      op_in = op;
      issue_in = 1'h1;
      @(negedge mclk_in);
      issue_in = 1'h0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_int;
    begin
      source_reg_a_in = 32'h7fffffff;
      source_reg_b_in = 32'h1;
      run(`AAADD_OP_ADD_NOTRAP);
      cmp(int_result_out, 32'h80000000);
      cmp(int_overflow_exc_out, 1'h0);
      source_reg_b_in = 32'h2;
      run(`AAADD_OP_ADD_TRAP);
      cmp(int_overflow_exc_out, 1'h1);
      cmp(int_we_out, 1'h0);
      @(negedge mclk_in);
      cmp(wb_data, 32'h80000000);
      source_reg_a_in = 32'h80000000;
      source_reg_b_in = 32'hffffffff;
      run(`AAADD_OP_ADD_TRAP);
      cmp(int_overflow_exc_out, 1'h1);
      source_reg_a_in = 32'hffffffff;
      source_reg_b_in = 32'h1;
      run(`AAADD_OP_ADD_TRAP);
      cmp({int_overflow_exc_out, int_we_out, int_result_out}, 34'h100000000);
      imm16_in = 16'hffff;
      source_reg_a_in = 32'h1;
      run(`AAADD_OP_ADD_IMM);
      cmp({int_overflow_exc_out, int_result_out}, 33'h0);
    end
  endtask

  task t_pc;
    begin
      pc_in = 32'h00001003;
      imm19_in = 19'h7ffff;
      run(`AAADD_OP_PC_WORD);
      cmp(int_result_out, 32'h00000ffc);
      imm19_in = 19'h3ffff;
      run(`AAADD_OP_PC_WORD);
      cmp(int_result_out, 32'h00100ffc);
      pc_in = 32'h12345678;
      imm16_in = 16'h8001;
      run(`AAADD_OP_PC_UPPER);
      cmp(int_result_out, 32'h92350000);
      cmp({int_overflow_exc_out, reserved_instr_exc_out}, 2'h0);
    end
  endtask

  task t_align;
    begin
      source_reg_a_in = 32'h11223344;
      source_reg_b_in = 32'haabbccdd;
      // Pointer zero is issued on purpose: discouraged but still defined
      for (k = 0; k < 4; k = k + 1) begin
        byte_pointer_field_in = k[1:0];
        run(`AAADD_OP_ALIGN);
        cmp(int_result_out, AL_EXP[k*32 +: 32]);
      end
    end
  endtask

  task t_abs;
    begin
      fp_source_a_in = 64'hffc00001;
      run(`AAADD_OP_FP_ABS);
      cmp({fp_cause_out, fp_result_out}, {5'h0, 64'h7fc00001});
      nonarith_magnitude_ctrl_in = 1'h0;
      fp_source_a_in = 64'hbf800000;
      run(`AAADD_OP_FP_ABS);
      cmp({fp_cause_out, fp_result_out}, {5'h0, 64'h3f800000});
      fp_source_a_in = 64'h7fc00000;
      run(`AAADD_OP_FP_ABS);
      cmp(fp_cause_out[4], 1'h1);
      cmp(fp_flags_out[4], 1'h1);
      ieee2008_capable_flag_in = 1'h0;
      nonarith_magnitude_ctrl_in = 1'h1;
      run(`AAADD_OP_FP_ABS);
      cmp(fp_cause_out[4], 1'h1);
      flags_clear_in = 1'h1;
      @(negedge mclk_in);
      flags_clear_in = 1'h0;
      @(negedge mclk_in);
      cmp(fp_flags_out, 5'h0);
    end
  endtask

  task t_add;
    begin
      fp_source_a_in = 64'h3f800000;
      fp_source_b_in = 64'h33800000;
      for (k = 0; k < 4; k = k + 1) begin
        rmode_in = k[1:0];
        run(`AAADD_OP_FP_ADD);
        cmp(fp_result_out, {32'h0, RM_EXP[k*32 +: 32]});
        cmp(fp_cause_out[0], 1'h1);
      end
      cmp(fp_flags_out[0], 1'h1);
      rmode_in = `AAADD_RM_NEAR;
      fp_source_a_in = 64'h7f7fffff;
      fp_source_b_in = 64'h7f7fffff;
      run(`AAADD_OP_FP_ADD);
      cmp({fp_cause_out[2], fp_result_out}, {1'h1, 64'h7f800000});
      fp_source_b_in = 64'hff800000;
      fp_source_a_in = 64'h7f800000;
      run(`AAADD_OP_FP_ADD);
      cmp(fp_cause_out[4], 1'h1);
      fp_source_a_in = 64'h00000001;
      run(`AAADD_OP_FP_ADD);
      cmp({unimpl_op_exc_out, fp_we_out}, 2'h2);
      fmt_in = `AAADD_FMT_D;
      fp_source_a_in = 64'h3ff0000000000000;
      fp_source_b_in = 64'h3ff0000000000000;
      run(`AAADD_OP_FP_ADD);
      cmp(fp_result_out, 64'h4000000000000000);
      cmp({fp_we_out, result_dest_out}, 6'h25);
      fmt_in = 2'h2;
      run(`AAADD_OP_FP_ADD);
      cmp(reserved_instr_exc_out, 1'h1);
      fmt_in = `AAADD_FMT_S;
      cop1_usable_in = 1'h0;
      run(`AAADD_OP_FP_ABS);
      cmp({cop_unusable_exc_out, fp_we_out}, 2'h2);
      cop1_usable_in = 1'h1;
      flags_clear_in = 1'h1;
      trap_enable_in = 5'h01;
      fp_source_a_in = 64'h3f800000;
      fp_source_b_in = 64'h33800000;
      run(`AAADD_OP_FP_ADD);
      cmp({fp_exc_out, fp_we_out}, 2'h2);
      flags_clear_in = 1'h0;
      @(negedge mclk_in);
      cmp(fp_flags_out[0], 1'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_in = 1'h0;
    t_int;
    t_pc;
    t_align;
    t_abs;
    t_add;
    end_of_test;
  end
endmodule
